// *** rtl/brd_pkg.sv ***
// Package for the baud rate divider: register map, fields, reset values, carriers
package brd_pkg;

  // Register byte offsets on the AXI4-Lite bus
  localparam logic [4:0] BRD_OFS_TX_CTRL   = 5'h00;
  localparam logic [4:0] BRD_OFS_RX_CTRL   = 5'h04;
  localparam logic [4:0] BRD_OFS_BAUD_CTRL = 5'h08;
  localparam logic [4:0] BRD_OFS_DIV_HI    = 5'h0C;
  localparam logic [4:0] BRD_OFS_DIV_LO    = 5'h10;
  localparam logic [4:0] BRD_OFS_STATUS    = 5'h14;

  // Field positions
  localparam int BRD_BIT_SYNC      = 4;
  localparam int BRD_BIT_FAST      = 2;
  localparam int BRD_BIT_WIDE      = 3;
  localparam int BRD_BIT_RX_IDLE   = 6;

  // Writable bit masks
  localparam logic [7:0] BRD_TX_CTRL_WMASK   = 8'hFD;
  localparam logic [7:0] BRD_BAUD_CTRL_WMASK = 8'h3B;

  // Values after reset
  localparam logic [7:0] BRD_TX_CTRL_RST   = 8'h02;
  localparam logic [7:0] BRD_RX_CTRL_RST   = 8'h00;
  localparam logic [7:0] BRD_BAUD_CTRL_RST = 8'h00;
  localparam logic [7:0] BRD_DIV_RST       = 8'h00;

  // Prescaler terminal counts (clocks per prescaler wrap minus one)
  localparam logic [5:0] BRD_PRE_64 = 6'h3F;
  localparam logic [5:0] BRD_PRE_16 = 6'h0F;
  localparam logic [5:0] BRD_PRE_4  = 6'h03;

  // AXI responses
  localparam logic [1:0] BRD_RESP_OKAY   = 2'h0;
  localparam logic [1:0] BRD_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    BRD_MUL_64 = 2'h0,
    BRD_MUL_16 = 2'h1,
    BRD_MUL_4  = 2'h3
  } brd_mul_e;

  typedef struct packed {
    logic sync_mode;
    logic fast_rate_sel;
    logic wide_divider_sel;
  } brd_mode_s;

endpackage

// *** rtl/brd_baud_divider.sv ***
// Baud rate divider with AXI4-Lite register access
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
module brd_baud_divider
  import brd_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address and data
  input  wire logic [4:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [4:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Receiver status from the serial port
  input  wire logic        rx_idle_flag,
  // Bit-rate tick to transmitter and receiver
  output logic             baud_tick
);

  //////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [7:0]  tx_ctrl_q;
  logic [7:0]  rx_ctrl_q;
  logic [7:0]  baud_ctrl_q;
  logic [7:0]  div_hi_q;
  logic [7:0]  div_lo_q;
  logic        rx_idle_s1_q;
  logic        rx_idle_q;
  logic [4:0]  aw_addr_q;
  logic        aw_have_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        w_have_q;
  logic        wr_fire;
  logic        wr_hit;
  logic        div_write;
  brd_mode_s   mode;
  brd_mul_e    mul;
  logic [5:0]  pre_q;
  logic [5:0]  pre_max;
  logic [15:0] cnt_q;
  logic [15:0] div_n;
  logic        pre_wrap;
  logic        cnt_wrap;

  // Receiver idle comes from another block's clock region; synchronise it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_idle_s1_q <= 1'b1;
      rx_idle_q    <= 1'b1;
    end else begin
      rx_idle_s1_q <= rx_idle_flag;
      rx_idle_q    <= rx_idle_s1_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path: address and data taken in either order
  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q     <= 1'b0;
      aw_addr_q     <= 5'h00;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_have_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q     <= 1'b0;
      w_data_q     <= 32'h0000_0000;
      w_strb_q     <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_have_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_have_q <= 1'b0;
      end
    end
  end

  always_comb begin
    case (aw_addr_q)
      BRD_OFS_TX_CTRL, BRD_OFS_RX_CTRL, BRD_OFS_BAUD_CTRL,
      BRD_OFS_DIV_HI, BRD_OFS_DIV_LO, BRD_OFS_STATUS: wr_hit = 1'b1;
      default:                                          wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= BRD_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? BRD_RESP_OKAY : BRD_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control registers; only byte lane 0 carries data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_ctrl_q   <= BRD_TX_CTRL_RST;
      rx_ctrl_q   <= BRD_RX_CTRL_RST;
      baud_ctrl_q <= BRD_BAUD_CTRL_RST;
      div_hi_q    <= BRD_DIV_RST;
      div_lo_q    <= BRD_DIV_RST;
    end else if (wr_fire && w_strb_q[0]) begin
      case (aw_addr_q)
        BRD_OFS_TX_CTRL:   tx_ctrl_q <= (w_data_q[7:0] & BRD_TX_CTRL_WMASK) | (tx_ctrl_q & ~BRD_TX_CTRL_WMASK);
        BRD_OFS_RX_CTRL:   rx_ctrl_q <= w_data_q[7:0];
        BRD_OFS_BAUD_CTRL: baud_ctrl_q <= w_data_q[7:0] & BRD_BAUD_CTRL_WMASK;
        BRD_OFS_DIV_HI:    div_hi_q <= w_data_q[7:0];
        BRD_OFS_DIV_LO:    div_lo_q <= w_data_q[7:0];
        default:           ;
      endcase
    end
  end

  assign div_write = wr_fire && w_strb_q[0] &&
                     (aw_addr_q == BRD_OFS_DIV_HI || aw_addr_q == BRD_OFS_DIV_LO);

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= BRD_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= BRD_RESP_OKAY;
        case (s_axi_araddr)
          BRD_OFS_TX_CTRL:   s_axi_rdata <= {24'h000000, tx_ctrl_q};
          BRD_OFS_RX_CTRL:   s_axi_rdata <= {24'h000000, rx_ctrl_q};
          BRD_OFS_BAUD_CTRL: s_axi_rdata <= {24'h000000, baud_ctrl_q[7], rx_idle_q, baud_ctrl_q[5:0]};
          BRD_OFS_DIV_HI:    s_axi_rdata <= {24'h000000, div_hi_q};
          BRD_OFS_DIV_LO:    s_axi_rdata <= {24'h000000, div_lo_q};
          BRD_OFS_STATUS:    s_axi_rdata <= {16'h0000, cnt_q};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= BRD_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Mode decode
  assign mode = '{sync_mode:        tx_ctrl_q[BRD_BIT_SYNC],
                  fast_rate_sel:    tx_ctrl_q[BRD_BIT_FAST],
                  wide_divider_sel: baud_ctrl_q[BRD_BIT_WIDE]};

  always_comb begin
    if (mode.sync_mode) begin
      mul = BRD_MUL_4;
    end else begin
      case ({mode.wide_divider_sel, mode.fast_rate_sel})
        2'b00:   mul = BRD_MUL_64;
        2'b01:   mul = BRD_MUL_16;
        2'b10:   mul = BRD_MUL_16;
        2'b11:   mul = BRD_MUL_4;
        default: mul = BRD_MUL_64;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Divider: prescaler sets the multiplier, counter counts n+1 wraps

  always_comb begin
    case (mul)
      BRD_MUL_64: pre_max = BRD_PRE_64;
      BRD_MUL_16: pre_max = BRD_PRE_16;
      BRD_MUL_4:  pre_max = BRD_PRE_4;
      default:    pre_max = BRD_PRE_64;
    endcase
  end

  // Wide mode joins both bytes; narrow mode ignores the high byte
  assign div_n    = mode.wide_divider_sel ? {div_hi_q, div_lo_q} : {8'h00, div_lo_q};
  assign pre_wrap = (pre_q >= pre_max);
  assign cnt_wrap = pre_wrap && (cnt_q >= div_n);

  // Free running; a divisor write restarts the period at once
  always_ff @(posedge aclk) begin
    if (!aresetn || div_write) begin
      pre_q <= 6'h00;
      cnt_q <= 16'h0000;
    end else if (pre_wrap) begin
      pre_q <= 6'h00;
      cnt_q <= cnt_wrap ? 16'h0000 : cnt_q + 16'h0001;
    end else begin
      pre_q <= pre_q + 6'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      baud_tick <= 1'b0;
    end else begin
      baud_tick <= cnt_wrap && !div_write;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Assertions
  // Gap equals the bit period when a tick shows; a tick restarts it at one
  logic [21:0] gap_q;
  logic        mode_chg_q;
  always_ff @(posedge aclk) begin
    if (!aresetn || div_write) begin
      gap_q <= 22'h000000;
    end else if (baud_tick) begin
      gap_q <= 22'h000001;
    end else begin
      gap_q <= gap_q + 22'h000001;
    end
  end

  // Mode rewrite mid-period gives one odd period; that one is not checked
  always_ff @(posedge aclk) begin
    if (!aresetn || div_write) begin
      mode_chg_q <= 1'b0;
    end else if (wr_fire && w_strb_q[0] && (aw_addr_q == BRD_OFS_TX_CTRL || aw_addr_q == BRD_OFS_BAUD_CTRL)) begin
      mode_chg_q <= 1'b1;
    end else if (baud_tick) begin
      mode_chg_q <= 1'b0;
    end
  end

  property p_sync_fast_ignored;
    @(posedge aclk) disable iff (!aresetn) mode.sync_mode |-> mul == BRD_MUL_4;
  endproperty
  a_sync_fast_ignored: assert property (p_sync_fast_ignored) else $error("sync mode not x4");

  property p_reset_narrow;
    @(posedge aclk) !aresetn |=> !baud_ctrl_q[BRD_BIT_WIDE];
  endproperty
  a_reset_narrow: assert property (p_reset_narrow) else $error("wide select set after reset");

  property p_div_write_clears;
    @(posedge aclk) disable iff (!aresetn) div_write |=> cnt_q == 16'h0000 && pre_q == 6'h00 && !baud_tick;
  endproperty
  a_div_write_clears: assert property (p_div_write_clears) else $error("divisor write did not clear");

  property p_narrow_ignores_hi;
    @(posedge aclk) disable iff (!aresetn) !mode.wide_divider_sel |-> div_n[15:8] == 8'h00;
  endproperty
  a_narrow_ignores_hi: assert property (p_narrow_ignores_hi) else $error("high byte used in 8-bit");

  property p_async_slow_narrow;
    @(posedge aclk) disable iff (!aresetn)
      (!mode.sync_mode && !mode.fast_rate_sel && !mode.wide_divider_sel) |-> pre_max == 6'h3F;
  endproperty
  a_async_slow_narrow: assert property (p_async_slow_narrow) else $error("8-bit slow not x64");

  property p_async_fast_wide;
    @(posedge aclk) disable iff (!aresetn)
      (!mode.sync_mode && mode.fast_rate_sel && mode.wide_divider_sel) |-> pre_max == 6'h03;
  endproperty
  a_async_fast_wide: assert property (p_async_fast_wide) else $error("16-bit fast not x4");

  property p_async_fast_narrow;
    @(posedge aclk) disable iff (!aresetn)
      (!mode.sync_mode && mode.fast_rate_sel && !mode.wide_divider_sel) |-> pre_max == 6'h0F;
  endproperty
  a_async_fast_narrow: assert property (p_async_fast_narrow) else $error("8-bit fast not x16");

  property p_tick_period;
    @(posedge aclk) disable iff (!aresetn)
      baud_tick && !mode_chg_q |-> gap_q == 22'((32'(pre_max) + 32'd1) * (32'(div_n) + 32'd1));
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("tick period wrong");

  property p_tick_one_cycle;
    @(posedge aclk) disable iff (!aresetn) baud_tick |=> !baud_tick;
  endproperty
  a_tick_one_cycle: assert property (p_tick_one_cycle) else $error("tick longer than one cycle");

  property p_sync_pre_bound;
    @(posedge aclk) disable iff (!aresetn)
      mode.sync_mode && $stable(tx_ctrl_q) |-> pre_q <= BRD_PRE_4;
  endproperty
  a_sync_pre_bound: assert property (p_sync_pre_bound) else $error("sync prescaler beyond x4");

  property p_tick_free_running;
    @(posedge aclk) disable iff (!aresetn) gap_q <= 22'h100000;
  endproperty
  a_tick_free_running: assert property (p_tick_free_running) else $error("divider stalled");

endmodule

// *** sim/brd_baud_divider_tb.sv ***
// Self-checking bench for the baud rate divider: register access and tick periods
`timescale 1ns/100ps
module brd_baud_divider_tb
  import brd_pkg::*;
;
  logic        aclk = 1'b0;
  logic        aresetn;
  logic [4:0]  s_axi_awaddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [4:0]  s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  logic        rx_idle_flag;
  logic        baud_tick;
  int          err_count = 0;
  int          checked = 0;
  logic [1:0]  wr_q[$];
  logic [33:0] rd_q[$];
  int          tick_q[$];
  int          gap = 0;
  logic        bv_q = 1'b0;
  logic        div_wr = 1'b0;
  logic [3:0]  strb = 4'hF;
  logic [31:0] seed = 32'd68168;
  logic [7:0]  tx_v, bc_v, lo_v;
  int          n_div, m_mul;

  brd_baud_divider brd_baud_divider_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .rx_idle_flag, .baud_tick
  );

  always #12.5 aclk = ~aclk;

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task report_and_stop;
    if (wr_q.size() + rd_q.size() + tick_q.size() != 0) err_count++;
    if (err_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic axi_wr(input logic [4:0] a, input logic [7:0] d, input logic [1:0] r);
    int   n;
    logic aw_ok, w_ok;
    n = 0;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    div_wr = (a == BRD_OFS_DIV_HI) || (a == BRD_OFS_DIV_LO);
    wr_q.push_back(r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_wstrb <= strb;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok) && n < 100) begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready === 1'b1) begin
        s_axi_awvalid <= 1'b0;
        aw_ok = 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready === 1'b1) begin
        s_axi_wvalid <= 1'b0;
        w_ok = 1'b1;
      end
    end
    do begin
      @(posedge aclk);
      n++;
    end while (s_axi_bvalid !== 1'b1 && n < 200);
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [4:0] a, input logic [7:0] d, input logic [1:0] r);
    int n;
    n = 0;
    rd_q.push_back({r, 24'h000000, d});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (s_axi_arready !== 1'b1 && n < 100);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1 && n < 200) begin
      @(posedge aclk);
      n++;
    end
    s_axi_rready <= 1'b0;
  endtask

  // Returns just after the edge that carried a tick, so a note pushed now waits for the next one
  task automatic wait_tick;
    int n;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (baud_tick !== 1'b1 && n < 20000);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Gap counts edges since the last tick, or since the edge a divisor write landed
  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready && wr_q.size() > 0) check({32'h0, s_axi_bresp}, {32'h0, wr_q.pop_front()});
    if (s_axi_rvalid && s_axi_rready && rd_q.size() > 0) check({s_axi_rresp, s_axi_rdata}, rd_q.pop_front());
    if (baud_tick === 1'b1) begin
      if (tick_q.size() > 0) check(34'(gap), 34'(tick_q.pop_front()));
      gap <= 1;
    end else if (s_axi_bvalid && !bv_q && div_wr) gap <= 2;
    else gap <= gap + 1;
    bv_q <= s_axi_bvalid;
  end

  initial begin
    repeat (100000) @(posedge aclk);
    err_count++;
    report_and_stop;
  end

  initial begin
    aresetn <= 1'b0;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} <= '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= '0;
    rx_idle_flag <= 1'b1;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(BRD_OFS_TX_CTRL, BRD_TX_CTRL_RST, BRD_RESP_OKAY);
    axi_rd(BRD_OFS_RX_CTRL, BRD_RX_CTRL_RST, BRD_RESP_OKAY);
    axi_rd(BRD_OFS_DIV_HI, BRD_DIV_RST, BRD_RESP_OKAY);
    axi_rd(BRD_OFS_DIV_LO, BRD_DIV_RST, BRD_RESP_OKAY);
    axi_rd(BRD_OFS_BAUD_CTRL, 8'h40, BRD_RESP_OKAY);
    axi_wr(5'h18, 8'hAA, BRD_RESP_SLVERR);
    axi_rd(5'h1C, 8'h00, BRD_RESP_SLVERR);
    // Default narrow slow mode with divisor zero
    wait_tick;
    tick_q.push_back(64);
    wait_tick;
    // Every mode combination; high byte set so narrow modes prove they ignore it
    for (int c = 0; c < 8; c++) begin
      seed = lfsr_next(seed);
      tx_v = (seed[7:0] & 8'hEB) | (c[2] ? 8'h10 : 8'h00) | (c[0] ? 8'h04 : 8'h00);
      bc_v = (seed[15:8] & 8'hF7) | (c[1] ? 8'h08 : 8'h00);
      lo_v = {3'b000, seed[20:16]};
      axi_wr(BRD_OFS_TX_CTRL, tx_v, BRD_RESP_OKAY);
      rx_idle_flag <= seed[24];
      axi_wr(BRD_OFS_BAUD_CTRL, bc_v, BRD_RESP_OKAY);
      axi_wr(BRD_OFS_DIV_HI, 8'h01, BRD_RESP_OKAY);
      axi_wr(BRD_OFS_DIV_LO, lo_v, BRD_RESP_OKAY);
      n_div = c[1] ? 256 + int'(lo_v) : int'(lo_v);
      m_mul = c[2] ? 4 : (c[1] && c[0]) ? 4 : (c[1] || c[0]) ? 16 : 64;
      #1;
      tick_q.push_back(m_mul * (n_div + 1) + 1);
      // Count read four cycles after the clear, before the first prescaler wrap takes effect
      axi_rd(BRD_OFS_STATUS, 8'h00, BRD_RESP_OKAY);
      wait_tick;
      tick_q.push_back(m_mul * (n_div + 1));
      wait_tick;
      axi_rd(BRD_OFS_TX_CTRL, (tx_v & BRD_TX_CTRL_WMASK) | (BRD_TX_CTRL_RST & ~BRD_TX_CTRL_WMASK), BRD_RESP_OKAY);
      axi_rd(BRD_OFS_BAUD_CTRL, (bc_v & BRD_BAUD_CTRL_WMASK) | {1'b0, seed[24], 6'h00}, BRD_RESP_OKAY);
      axi_rd(BRD_OFS_DIV_LO, lo_v, BRD_RESP_OKAY);
      axi_rd(BRD_OFS_DIV_HI, 8'h01, BRD_RESP_OKAY);
    end
    // Plain storage, then a write with lane 0 disabled must leave it alone
    axi_wr(BRD_OFS_RX_CTRL, seed[31:24], BRD_RESP_OKAY);
    strb = 4'hE;
    axi_wr(BRD_OFS_RX_CTRL, ~seed[31:24], BRD_RESP_OKAY);
    strb = 4'hF;
    axi_rd(BRD_OFS_RX_CTRL, seed[31:24], BRD_RESP_OKAY);
    // Mid-run reset must bring back narrow slow mode and reset values
    aresetn      <= 1'b0;
    rx_idle_flag <= 1'b1;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(BRD_OFS_RX_CTRL, BRD_RX_CTRL_RST, BRD_RESP_OKAY);
    axi_rd(BRD_OFS_TX_CTRL, BRD_TX_CTRL_RST, BRD_RESP_OKAY);
    axi_rd(BRD_OFS_BAUD_CTRL, 8'h40, BRD_RESP_OKAY);
    wait_tick;
    tick_q.push_back(64);
    wait_tick;
    repeat (4) @(posedge aclk);
    report_and_stop;
  end
endmodule
